/* logic/bus_fault_rerun_halt_reset_ctrl.sv */
// bus cycle termination by fault/stop, re-run, double fault and reset line
// assumes core side on sys_clk; pins asynchronous, active high internally
//
// Contract
// - fault ends cycle without transfer acknowledge
// - early fault still negates strobe in last state
// - buses float while fault stays asserted
// - exception pushes pc/sr, info, fetches vector
// - fault vector read from address 8
// - fault plus stop ends cycle, waits
// - re-run repeats identical cycle after stop release
// - locked cycles never re-run, trap instead
// - stop held blocks new bus cycles
// - single step completes exactly one cycle
// - stopped after cycle floats address, data
// - bus grants continue while stopped
// - fault during stacking gives permanent halt
// - fault before next instruction is double
// - re-runs never count toward double fault
// - fault during boot halts until reset
// - reset line two-way; full reset needs stop
// - reset loads stack, pc vectors, mask seven
// - reset instruction drives line 124 clocks
// - reset with stop ten clocks resets
// - async inputs synchronised before use
`timescale 1ns/1ps
module bus_fault_rerun_halt_reset_ctrl #(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              bus_fault_in,
  input  wire logic              transfer_ack_in,
  input  wire logic              stop_in,
  input  wire logic              bus_req_in,
  input  wire logic              reset_line_in,
  output logic                   reset_line_out,
  output logic                   reset_line_oe,
  output logic                   bus_grant,
  output logic                   addr_strobe,
  output logic [ADDR_W-1:0]      addr_out,
  output logic                   addr_oe,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe,
  input  wire logic [DATA_W-1:0] data_in,
  output logic [2:0]             fc_out,
  output logic                   write_out,
  input  wire logic              cyc_req,
  input  wire logic              cyc_write,
  input  wire logic              cyc_rmw,
  input  wire logic [2:0]        cyc_fc,
  input  wire logic [ADDR_W-1:0] cyc_addr,
  input  wire logic [DATA_W-1:0] cyc_wdata,
  output logic                   cyc_ready,
  output logic                   cyc_done,
  output logic [DATA_W-1:0]      cyc_rdata,
  input  wire logic [ADDR_W-1:0] stack_addr,
  input  wire logic [DATA_W-1:0] pc_sr_word,
  input  wire logic [DATA_W-1:0] fault_info_word,
  input  wire logic              instr_start,
  input  wire logic              reset_instr,
  output logic [DATA_W-1:0]      ssp_out,
  output logic                   ssp_load,
  output logic [DATA_W-1:0]      pc_out,
  output logic                   pc_load,
  output logic [2:0]             int_mask_out,
  output logic                   stopped,
  output logic                   double_fault,
  output fault_ctrl_pkg::seq_e   seq_state
);
  import fault_ctrl_pkg::*;

  if (ADDR_W < 4 || DATA_W < 8) begin : g_bad_width
    $error("ADDR_W must be >= 4 and DATA_W >= 8");
  end

  // ***********************************
  // input synchronisers
  // ***********************************
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] meta_reg;
  logic [NSYNC-1:0] sync_reg;
  logic [NSYNC-1:0] pins;
  logic             fault_s;
  logic             ack_s;
  logic             stop_s;
  logic             rstin_s;
  logic             breq_s;

  assign pins = {bus_req_in, reset_line_in, stop_in, transfer_ack_in, bus_fault_in};

  // two flops per pin; one extra cycle of latency bought for metastability margin
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        meta_reg[i] <= 1'b0;
        sync_reg[i] <= 1'b0;
      end else begin
        meta_reg[i] <= pins[i];
        sync_reg[i] <= meta_reg[i];
      end
    end
  end

  assign fault_s = sync_reg[0];
  assign ack_s   = sync_reg[1];
  assign stop_s  = sync_reg[2];
  assign rstin_s = sync_reg[3];
  assign breq_s  = sync_reg[4];

  // ***********************************
  // reset line: output pulse and full reset detect
  // ***********************************
  logic [7:0] rout_cnt_reg;
  logic [3:0] full_cnt_reg;
  logic       full_hold;
  logic       soft_rst;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rout_cnt_reg <= 8'h00;
    end else if (rout_cnt_reg != 8'h00) begin
      rout_cnt_reg <= rout_cnt_reg - 8'h01;
    end else if (reset_instr) begin
      rout_cnt_reg <= RSTOUT_CYCLES;
    end
  end

  assign reset_line_oe  = rout_cnt_reg != 8'h00;
  assign reset_line_out = reset_line_oe;

  // own drive of the line must not reset ourselves
  assign full_hold = rstin_s && stop_s && !reset_line_oe;
  assign soft_rst  = full_hold && (full_cnt_reg == FULLRST_CYCLES - 4'h1);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      full_cnt_reg <= 4'h0;
    end else if (!full_hold) begin
      full_cnt_reg <= 4'h0;
    end else if (full_cnt_reg != FULLRST_CYCLES) begin
      full_cnt_reg <= full_cnt_reg + 4'h1;
    end
  end

  // ***********************************
  // cycle source and launch
  // ***********************************
  seq_e              seq_reg;
  seq_e              home_reg;
  logic              bact_reg;
  logic [2:0]        bst_reg;
  logic              fhit_reg;
  logic              rerun_reg;
  logic              exc_reg;
  logic              boot_reg;
  logic              dbl_reg;
  logic              grant_reg;
  logic              wants;
  logic              launch;
  logic              end_cyc;
  logic [ADDR_W-1:0] src_addr;
  logic [DATA_W-1:0] src_wdata;
  logic [2:0]        src_fc;
  logic              src_wr;
  logic              src_rmw;
  logic [ADDR_W-1:0] cur_addr_reg;
  logic [DATA_W-1:0] cur_wdata_reg;
  logic [2:0]        cur_fc_reg;
  logic              cur_wr_reg;
  logic              cur_rmw_reg;

  always_comb begin
    wants     = 1'b1;
    src_addr  = cyc_addr;
    src_wdata = cyc_wdata;
    src_fc    = FC_SUPER_PROG;
    src_wr    = 1'b0;
    src_rmw   = 1'b0;
    case (seq_reg)
      SEQ_BOOT_SSP: src_addr = ADDR_W'(VEC_SSP);
      SEQ_BOOT_PC:  src_addr = ADDR_W'(VEC_PC);
      SEQ_RUN: begin
        wants   = cyc_req;
        src_fc  = cyc_fc;
        src_wr  = cyc_write;
        src_rmw = cyc_rmw;
      end
      SEQ_EXC_PC: begin
        src_addr  = stack_addr;
        src_wdata = pc_sr_word;
        src_fc    = FC_SUPER_DATA;
        src_wr    = 1'b1;
      end
      SEQ_EXC_INFO: begin
        src_addr  = stack_addr - ADDR_W'(STK_STEP);
        src_wdata = fault_info_word;
        src_fc    = FC_SUPER_DATA;
        src_wr    = 1'b1;
      end
      SEQ_EXC_VEC: src_addr = ADDR_W'(VEC_FAULT);
      SEQ_RERUN:   wants = 1'b1;
      default:     wants = 1'b0;
    endcase
  end

  // stop held: no new cycle; a cycle already begun is cut short only by a full reset (soft_rst)
  assign launch    = wants && !bact_reg && !stop_s && !breq_s && !grant_reg
                     && !soft_rst;
  assign cyc_ready = launch && (seq_reg == SEQ_RUN);
  assign end_cyc   = bact_reg && (bst_reg == BS_LAST);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_addr_reg  <= '0;
      cur_wdata_reg <= '0;
      cur_fc_reg    <= 3'h0;
      cur_wr_reg    <= 1'b0;
      cur_rmw_reg   <= 1'b0;
    end else if (launch && seq_reg != SEQ_RERUN) begin
      cur_addr_reg  <= src_addr;
      cur_wdata_reg <= src_wdata;
      cur_fc_reg    <= src_fc;
      cur_wr_reg    <= src_wr;
      cur_rmw_reg   <= src_rmw;
    end
  end

  // ***********************************
  // bus state engine
  // ***********************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bact_reg <= 1'b0;
      bst_reg  <= BS_FIRST;
      fhit_reg <= 1'b0;
    end else if (soft_rst) begin
      bact_reg <= 1'b0;
      bst_reg  <= BS_FIRST;
      fhit_reg <= 1'b0;
    end else if (launch) begin
      bact_reg <= 1'b1;
      bst_reg  <= BS_FIRST;
      fhit_reg <= 1'b0;
    end else if (bact_reg) begin
      if (fault_s && bst_reg <= BS_WAIT) begin
        fhit_reg <= 1'b1;
      end
      if (bst_reg == BS_LAST) begin
        bact_reg <= 1'b0;
      end else if (bst_reg != BS_WAIT || ack_s || fault_s || fhit_reg) begin
        bst_reg <= bst_reg + 3'h1;
      end
    end
  end

  // strobe drops in the last state on every path, faulted or not
  assign addr_strobe = bact_reg && bst_reg >= BS_STROBE_ON && bst_reg != BS_LAST;
  assign addr_oe     = bact_reg || (seq_reg == SEQ_RUN && !stop_s && !grant_reg);
  assign data_oe     = bact_reg && cur_wr_reg;
  assign addr_out    = cur_addr_reg;
  assign data_out    = cur_wdata_reg;
  assign fc_out      = cur_fc_reg;
  assign write_out   = cur_wr_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_rdata <= '0;
    end else if (bact_reg && bst_reg == BS_LATCH) begin
      cyc_rdata <= data_in;
    end
  end

  // arbitration ignores stop and double fault alike
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      grant_reg <= 1'b0;
    end else begin
      grant_reg <= breq_s && !bact_reg && !launch;
    end
  end
  assign bus_grant = grant_reg;

  // ***********************************
  // sequencer: boot, run, fault, re-run, exception
  // ***********************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_reg      <= SEQ_BOOT_SSP;
      home_reg     <= SEQ_RUN;
      rerun_reg    <= 1'b0;
      exc_reg      <= 1'b0;
      boot_reg     <= 1'b1;
      dbl_reg      <= 1'b0;
      int_mask_out <= INT_MASK_RESET;
      ssp_out      <= '0;
      pc_out       <= '0;
      ssp_load     <= 1'b0;
      pc_load      <= 1'b0;
      cyc_done     <= 1'b0;
    end else if (soft_rst) begin
      seq_reg      <= SEQ_BOOT_SSP;
      rerun_reg    <= 1'b0;
      exc_reg      <= 1'b0;
      boot_reg     <= 1'b1;
      dbl_reg      <= 1'b0;
      int_mask_out <= INT_MASK_RESET;
      ssp_load     <= 1'b0;
      pc_load      <= 1'b0;
      cyc_done     <= 1'b0;
    end else begin
      ssp_load <= 1'b0;
      pc_load  <= 1'b0;
      cyc_done <= 1'b0;
      if (instr_start) begin
        exc_reg  <= 1'b0;
        boot_reg <= 1'b0;
      end
      if (end_cyc && fhit_reg) begin
        if (stop_s && !cur_rmw_reg) begin
          seq_reg   <= SEQ_FLOAT;
          home_reg  <= seq_reg;
          rerun_reg <= 1'b1;
        end else if (exc_reg || boot_reg || seq_reg != SEQ_RUN) begin
          seq_reg <= SEQ_DEAD;
          dbl_reg <= 1'b1;
        end else begin
          seq_reg   <= SEQ_FLOAT;
          rerun_reg <= 1'b0;
          exc_reg   <= 1'b1;
        end
      end else if (end_cyc) begin
        case (seq_reg)
          SEQ_BOOT_SSP: begin
            ssp_out  <= cyc_rdata;
            ssp_load <= 1'b1;
            seq_reg  <= SEQ_BOOT_PC;
          end
          SEQ_BOOT_PC: begin
            pc_out  <= cyc_rdata;
            pc_load <= 1'b1;
            seq_reg <= SEQ_RUN;
          end
          SEQ_EXC_PC:   seq_reg <= SEQ_EXC_INFO;
          SEQ_EXC_INFO: seq_reg <= SEQ_EXC_VEC;
          SEQ_EXC_VEC: begin
            pc_out  <= cyc_rdata;
            pc_load <= 1'b1;
            seq_reg <= SEQ_RUN;
          end
          SEQ_RUN:      cyc_done <= 1'b1;
          default:      seq_reg <= seq_reg;
        endcase
      end else begin
        case (seq_reg)
          SEQ_FLOAT: begin
            if (!fault_s) begin
              seq_reg <= rerun_reg ? SEQ_RERUN : SEQ_EXC_PC;
            end
          end
          SEQ_RERUN: begin
            if (launch) begin
              seq_reg <= home_reg;
            end
          end
          default: seq_reg <= seq_reg;
        endcase
      end
    end
  end

  logic stopped_reg;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stopped_reg <= 1'b0;
    end else begin
      stopped_reg <= dbl_reg || (stop_s && !bact_reg);
    end
  end
  assign stopped      = stopped_reg;
  assign double_fault = dbl_reg;
  assign seq_state    = seq_reg;

  // ***********************************
  // checks
  // ***********************************
  chk_fault_ends: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (bact_reg && fault_s && !soft_rst) |-> ##[1:9] !bact_reg)
    else $error("faulted cycle did not end");
  chk_strobe_last: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (bact_reg && bst_reg == BS_LAST) |-> !addr_strobe)
    else $error("strobe still on in last bus state");
  chk_float_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (seq_reg == SEQ_FLOAT) |-> (!addr_oe && !data_oe && !bact_reg))
    else $error("buses driven while fault held");
  chk_vec_fault: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (seq_reg == SEQ_EXC_VEC && bact_reg) |-> (cur_addr_reg == ADDR_W'(VEC_FAULT)))
    else $error("fault vector fetched from wrong address");
  chk_rerun_same: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (seq_reg == SEQ_RERUN) |=> ($stable(cur_addr_reg) && $stable(cur_wdata_reg)
      && $stable(cur_fc_reg) && $stable(cur_wr_reg)))
    else $error("re-run cycle differs from original");
  chk_rmw_rerun: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (seq_reg == SEQ_FLOAT) |-> !(rerun_reg && cur_rmw_reg))
    else $error("locked cycle queued for re-run");
  chk_stop_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(bact_reg) |-> !$past(stop_s))
    else $error("cycle started while stop held");
  chk_dbl_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (dbl_reg && !soft_rst) |=> (dbl_reg && seq_reg == SEQ_DEAD && !bact_reg))
    else $error("double fault halt left without reset");
  chk_rst_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(reset_line_oe) |-> ##123 reset_line_oe ##1 !reset_line_oe)
    else $error("reset line pulse not 124 clocks");
  chk_full_reset: assert property (@(posedge sys_clk) disable iff (!rst_b)
    soft_rst |=> (seq_reg == SEQ_BOOT_SSP && int_mask_out == INT_MASK_RESET))
    else $error("full reset did not restart boot");

endmodule

/* logic/fault_ctrl_pkg.sv */
// constants and sequencer states for the bus fault / stop / reset controller
// assumes a single 10 MHz processor clock; no register bus
package fault_ctrl_pkg;

  // ***********************************
  // bus state numbering (one sys_clk per state, except BS_WAIT, which holds until ack or fault)
  // ***********************************
  localparam logic [2:0] BS_FIRST     = 3'h0;
  localparam logic [2:0] BS_STROBE_ON = 3'h2;
  localparam logic [2:0] BS_WAIT      = 3'h4;
  localparam logic [2:0] BS_LATCH     = 3'h6;
  localparam logic [2:0] BS_LAST      = 3'h7;

  // ***********************************
  // vector table and stacking
  // ***********************************
  localparam logic [23:0] VEC_SSP   = 24'h000000;
  localparam logic [23:0] VEC_PC    = 24'h000004;
  localparam logic [23:0] VEC_FAULT = 24'h000008;
  localparam logic [23:0] STK_STEP  = 24'h000002;
  localparam logic [2:0]  FC_SUPER_DATA  = 3'h5;
  localparam logic [2:0]  FC_SUPER_PROG  = 3'h6;
  localparam logic [2:0]  INT_MASK_RESET = 3'h7;

  // ***********************************
  // reset timing, in clock periods
  // ***********************************
  localparam logic [7:0] RSTOUT_CYCLES  = 8'h7C;
  localparam logic [3:0] FULLRST_CYCLES = 4'hA;

  typedef enum logic [8:0] {
    SEQ_BOOT_SSP = 9'h001,
    SEQ_BOOT_PC  = 9'h002,
    SEQ_RUN      = 9'h004,
    SEQ_FLOAT    = 9'h008,
    SEQ_RERUN    = 9'h010,
    SEQ_EXC_PC   = 9'h020,
    SEQ_EXC_INFO = 9'h040,
    SEQ_EXC_VEC  = 9'h080,
    SEQ_DEAD     = 9'h100
  } seq_e;

endpackage

/* test/bus_fault_rerun_halt_reset_ctrl_tb.sv */
// self-checking bench for the fault, stop and reset controller
// assumes fault_partner on the bus; stop and reset lines merged here
`timescale 1ns/1ps
module bus_fault_rerun_halt_reset_ctrl_tb;
  import fault_ctrl_pkg::*;
  typedef struct {logic wr; logic [3:0] aw; logic [23:0] a; logic [15:0] wd, rd;} row_s;
  logic        sys_clk, rst_b, bus_fault_in, transfer_ack_in, stop_in, bus_req_in;
  logic        reset_line_in, reset_line_out, reset_line_oe, bus_grant, addr_strobe;
  logic        addr_oe, data_oe, write_out, cyc_req, cyc_write, cyc_rmw, cyc_ready;
  logic        cyc_done, ssp_load, pc_load, stopped, double_fault, instr_start;
  logic        reset_instr, stop_req, tb_stop, ext_rst, arm, with_stop, as_q;
  logic [23:0] addr_out, cyc_addr, stack_addr;
  logic [15:0] data_out, data_in, cyc_wdata, cyc_rdata, pc_sr_word, fault_info_word;
  logic [15:0] ssp_out, pc_out;
  logic [2:0]  fc_out, cyc_fc, int_mask_out;
  logic [3:0]  ack_wait;
  logic [1:0]  n_fault;
  seq_e        seq_state;
  logic [43:0] trace[$];
  int          n_mismatch, comparisons, n_ready, n_done, n_float, n_rst, i;
  row_s        rows[4] = '{'{1'b0, 4'h0, 24'h000010, 16'h0000, 16'h5A4A},
                           '{1'b1, 4'h0, 24'h000020, 16'h1234, 16'h1234},
                           '{1'b0, 4'h3, 24'hFFFFFE, 16'h0000, 16'hA5A4},
                           '{1'b1, 4'h5, 24'h000022, 16'hA5C3, 16'hA5C3}};

  assign stop_in       = stop_req | tb_stop;
  assign reset_line_in = ext_rst | (reset_line_oe & reset_line_out);

  bus_fault_rerun_halt_reset_ctrl i_bus_fault_rerun_halt_reset_ctrl (.sys_clk, .rst_b,
    .bus_fault_in, .transfer_ack_in, .stop_in, .bus_req_in, .reset_line_in, .reset_line_out,
    .reset_line_oe, .bus_grant, .addr_strobe, .addr_out, .addr_oe, .data_out, .data_oe,
    .data_in, .fc_out, .write_out, .cyc_req, .cyc_write, .cyc_rmw, .cyc_fc, .cyc_addr,
    .cyc_wdata, .cyc_ready, .cyc_done, .cyc_rdata, .stack_addr, .pc_sr_word,
    .fault_info_word, .instr_start, .reset_instr, .ssp_out, .ssp_load, .pc_out, .pc_load,
    .int_mask_out, .stopped, .double_fault, .seq_state);
  fault_partner i_fault_partner (.sys_clk, .addr_strobe, .addr_out, .ack_wait, .n_fault,
    .with_stop, .arm, .transfer_ack_in, .bus_fault_in, .stop_req, .data_in);

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ***********************************
  // bus monitor
  // ***********************************
  always @(posedge sys_clk) begin
    as_q <= addr_strobe;
    if (addr_strobe === 1'b1 && as_q !== 1'b1)
      trace.push_back({fc_out, write_out, addr_out, data_out});
    if (cyc_ready === 1'b1) n_ready++;
    if (cyc_done === 1'b1) n_done++;
    if (reset_line_oe === 1'b1) n_rst++;
    if (bus_fault_in === 1'b1 && addr_strobe === 1'b0 && as_q === 1'b0
        && {addr_oe, data_oe} !== 2'b00)
      n_float++;
  end

  // ***********************************
  // tasks
  // ***********************************
  task automatic check_val(string what, logic [99:0] exp, logic [99:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic hit(int k);
    case (k)
      0: return cyc_done;
      1: return pc_load;
      2: return seq_state == SEQ_RUN;
      3: return seq_state == SEQ_DEAD;
      4: return cyc_ready;
      default: return addr_strobe;
    endcase
  endfunction

  task automatic wait_hit(int k, int lim);
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (hit(k) !== 1'b1 && i < lim);
    check_val("wait", 1, i < lim);
  endtask

  task automatic run_cycle(logic wr, logic rmw, logic [23:0] a, logic [15:0] wd);
    trace.delete();
    n_done = 0;
    cyc_write <= wr;
    cyc_rmw <= rmw;
    cyc_addr <= a;
    cyc_wdata <= wd;
    cyc_req <= 1'b1;
    // drop the request at the edge that took it, or a second cycle launches
    wait_hit(4, 400);
    cyc_req <= 1'b0;
  endtask

  task automatic arm_faults(logic [1:0] n, logic s);
    @(posedge sys_clk);
    n_fault <= n;
    with_stop <= s;
    arm <= 1'b1;
    @(posedge sys_clk);
    arm <= 1'b0;
  endtask

  task automatic pulse_start();
    @(posedge sys_clk);
    instr_start <= 1'b1;
    @(posedge sys_clk);
    instr_start <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ***********************************
  // sequence
  // ***********************************
  initial begin
    {rst_b, bus_req_in, cyc_req, cyc_write, cyc_rmw, instr_start, reset_instr} = 7'h00;
    {tb_stop, ext_rst, arm, with_stop, n_fault, ack_wait} = 10'h000;
    {cyc_addr, cyc_wdata, cyc_fc} = {24'h000000, 16'h0000, 3'h1};
    {stack_addr, pc_sr_word, fault_info_word} = {24'h0007F0, 16'h2700, 16'h0B0E};
    repeat (2) @(posedge sys_clk);
    check_val("reset", {3'h7, 1'b1, 1'b0}, {int_mask_out, seq_state == SEQ_BOOT_SSP, addr_oe});
    rst_b <= 1'b1;
    wait_hit(2, 400);
    check_val("boot", {VEC_SSP, VEC_PC, VEC_SSP[15:0] ^ 16'h5A5A, VEC_PC[15:0] ^ 16'h5A5A},
      {trace[0][39:16], trace[1][39:16], ssp_out, pc_out});
    foreach (rows[r]) begin
      ack_wait <= rows[r].aw;
      run_cycle(rows[r].wr, 1'b0, rows[r].a, rows[r].wd);
      wait_hit(0, 40);
      check_val("latency", 1, i >= 8 && i <= rows[r].aw + 12);
      @(posedge sys_clk);
      check_val("cycle", {3'h1, rows[r].wr, rows[r].a, rows[r].rd},
        {trace[0][43:16], rows[r].wr ? trace[0][15:0] : cyc_rdata});
    end
    // a fault before the first instruction would be a double fault
    pulse_start();
    arm_faults(2'h1, 1'b0);
    run_cycle(1'b0, 1'b0, 24'h000100, 16'h0000);
    wait_hit(1, 300);
    check_val("trap", {1'b0, 24'h000100, 1'b1, stack_addr, 1'b1, stack_addr - STK_STEP,
      1'b0, VEC_FAULT}, {trace[0][40:16], trace[1][40:16], trace[2][40:16],
      trace[3][40:16]});
    check_val("push", {FC_SUPER_DATA, pc_sr_word, fault_info_word, 32'h0},
      {trace[1][43:41], trace[1][15:0], trace[2][15:0], n_done});
    check_val("vector", VEC_FAULT[15:0] ^ 16'h5A5A, pc_out);
    pulse_start();
    arm_faults(2'h2, 1'b1);
    run_cycle(1'b1, 1'b0, 24'h000200, 16'hBEEF);
    wait_hit(0, 600);
    check_val("rerun", {1'b1, 3'h1, 1'b1, 24'h000200, 16'hBEEF, 1'b0},
      {trace.size() == 3, trace[0], double_fault});
    check_val("rerun same", {2{3'h1, 1'b1, 24'h000200, 16'hBEEF}}, {trace[1], trace[2]});
    arm_faults(2'h1, 1'b1);
    run_cycle(1'b0, 1'b1, 24'h000300, 16'h0000);
    wait_hit(1, 300);
    check_val("locked", {1'b1, stack_addr}, trace[1][40:16]);
    pulse_start();
    tb_stop <= 1'b1;
    repeat (4) @(posedge sys_clk);
    {n_ready, n_done} = 64'h0;
    cyc_addr <= 24'h000400;
    cyc_write <= 1'b0;
    cyc_req <= 1'b1;
    bus_req_in <= 1'b1;
    repeat (20) @(posedge sys_clk);
    check_val("halt", 4'b1101, {n_ready == 0, stopped, addr_oe, bus_grant});
    bus_req_in <= 1'b0;
    repeat (4) @(posedge sys_clk);
    tb_stop <= 1'b0;
    wait_hit(5, 40);
    tb_stop <= 1'b1;
    repeat (40) @(posedge sys_clk);
    check_val("step", {32'h1, 32'h1, 1'b1}, {n_ready, n_done, stopped});
    cyc_req <= 1'b0;
    tb_stop <= 1'b0;
    repeat (20) @(posedge sys_clk);
    n_rst = 0;
    reset_instr <= 1'b1;
    @(posedge sys_clk);
    reset_instr <= 1'b0;
    repeat (300) @(posedge sys_clk);
    check_val("rst out", {RSTOUT_CYCLES, 3'h7, 1'b1},
      {n_rst[7:0], int_mask_out, seq_state == SEQ_RUN});
    arm_faults(2'h2, 1'b0);
    run_cycle(1'b0, 1'b0, 24'h000500, 16'h0000);
    wait_hit(3, 300);
    // stopped follows the double fault flag by one clock
    @(posedge sys_clk);
    check_val("double", 2'b11, {double_fault, stopped});
    {ext_rst, tb_stop} <= 2'b11;
    repeat (9) @(posedge sys_clk);
    {ext_rst, tb_stop} <= 2'b00;
    repeat (4) @(posedge sys_clk);
    check_val("short reset", 1'b1, double_fault);
    arm_faults(2'h1, 1'b0);
    {ext_rst, tb_stop} <= 2'b11;
    repeat (12) @(posedge sys_clk);
    {ext_rst, tb_stop} <= 2'b00;
    @(posedge sys_clk);
    check_val("full reset", 2'b10, {seq_state == SEQ_BOOT_SSP, double_fault});
    wait_hit(3, 300);
    check_val("boot fault", 1'b1, double_fault);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    wait_hit(2, 400);
    check_val("restart", {1'b0, 32'h0}, {double_fault, n_float});
    end_of_test();
  end

  // tests need under a thousand clocks; generous cut-off
  initial begin
    #(100 * 20000);
    n_mismatch++;
    end_of_test();
  end
endmodule

/* test/fault_partner.sv */
// far-side model: memory that acknowledges, plus fault and stop sources
// assumes bench arms faults between bus cycles, one clock, no reset
`timescale 1ns/1ps
module fault_partner (
  input  wire logic        sys_clk,
  input  wire logic        addr_strobe,
  input  wire logic [23:0] addr_out,
  input  wire logic [3:0]  ack_wait,
  input  wire logic [1:0]  n_fault,
  input  wire logic        with_stop,
  input  wire logic        arm,
  output logic             transfer_ack_in,
  output logic             bus_fault_in,
  output logic             stop_req,
  output logic [15:0]      data_in
);
  logic [3:0] cnt;
  logic [1:0] left;
  logic [2:0] hold;

  initial begin
    {transfer_ack_in, bus_fault_in, stop_req} = 3'h0;
    {cnt, left, hold} = 9'h000;
    data_in = 16'h0000;
  end

  // ***********************************
  // answer, all changes on rising edges
  // ***********************************
  always @(posedge sys_clk) begin
    if (arm)
      left <= n_fault;
    // released data bus toggles so stale values never pass
    data_in <= addr_strobe ? (addr_out[15:0] ^ 16'h5A5A) : ~data_in;
    if (addr_strobe) begin
      cnt <= cnt + 4'h1;
      if (cnt == ack_wait && left != 2'h0) begin
        bus_fault_in <= 1'b1;
        stop_req     <= with_stop;
        left         <= left - 2'h1;
        hold         <= 3'h6;
      end else if (cnt == ack_wait)
        transfer_ack_in <= 1'b1;
    end else begin
      cnt             <= 4'h0;
      transfer_ack_in <= 1'b0;
      if (hold != 3'h0)
        hold <= hold - 3'h1;
      // fault drops two clocks ahead of stop
      if (hold == 3'h3)
        bus_fault_in <= 1'b0;
      if (hold == 3'h1)
        stop_req <= 1'b0;
    end
  end
endmodule
